// file: core/dfo_pkg.sv
// Constants shared by the frame-boundary and overhead port of one channel.
// Assumes a fixed frame length in bits and evenly spaced overhead positions.
package dfo_pkg;

    // =========================================================================
    // Frame geometry
    // =========================================================================
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] FRAME_LAST = 10'h3FF;    // Last bit index of a frame
    localparam logic [CNT_W-1:0] LAST_NIBBLE = 10'h3FC;   // First bit of the last nibble
    localparam logic [CNT_W-1:0] NONINS_POS = 10'h000;    // Overhead bit the terminal may not set
    localparam logic [5:0] OH_MASK = 6'h3F;               // Overhead every 64 bits
    localparam logic [5:0] OH_SLOT = 6'h00;               // Offset of overhead within a block
    localparam logic [5:0] OH_PRE = 6'h3F;                // Bit period just before overhead

    // =========================================================================
    // Receive side timing and lanes
    // =========================================================================
    localparam logic [1:0] NIB_LAST = 2'h3;     // Index of final bit within a nibble
    localparam int RX_OHB_LANE = 4;             // Packet byte bit on the boundary pin
    localparam int SYNC_W = 3;                  // Width of the transmit-side synchroniser

    // Synchroniser lane positions
    localparam int SY_CE = 0;
    localparam int SY_HDLC = 1;
    localparam int SY_FCS = 2;

endpackage : dfo_pkg

// file: core/dfo_sync.sv
// Two-flop level synchroniser for a small group of independent levels.
// Assumes each lane is a slow level or a toggle; no lane is read as a bus.
`timescale 1ns/1ps

module dfo_sync (
    input wire logic clk,                              // Destination clock
    input wire logic reset,                            // Asynchronous, active high
    input wire logic [dfo_pkg::SYNC_W-1:0] levelIn,    // Levels from another domain
    output logic [dfo_pkg::SYNC_W-1:0] levelOut        // Levels safe in clk domain
);

    typedef struct packed {
        logic [dfo_pkg::SYNC_W-1:0] stage1;
        logic [dfo_pkg::SYNC_W-1:0] stage2;
    } dfo_sync_s;

    dfo_sync_s state_q;
    dfo_sync_s state_d;

    // =========================================================================
    // Next state: first stage feeds only the second
    // =========================================================================
    always_comb begin
        state_d.stage1 = levelIn;
        state_d.stage2 = state_q.stage1;
    end

    // Register stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign levelOut = state_q.stage2;

endmodule : dfo_sync

// file: core/dfo_port.sv
// Terminal-side frame-boundary and overhead port of one framer channel.
// Receive side runs on ref_clk and makes its own output clock by division;
// transmit side runs on the terminal's input clock, which must run freely.
// Terminal logic driving transmit inputs is clocked by that same clock.
`timescale 1ns/1ps

module dfo_port (
    input wire logic ref_clk,                   // Receive-side clock, 10 MHz
    input wire logic reset,                     // Asynchronous, active high
    input wire logic clkEn,                     // Low freezes all state
    input wire logic nibbleMode,                // 1 nibble-parallel, 0 serial
    input wire logic hdlcOn,                    // Packet controller in use
    input wire logic rxLineBit,                 // Received payload bit
    input wire logic rxLineFirst,               // rxLineBit is first bit of frame
    input wire logic rxOverheadFirst,           // First overhead bit of frame presented
    input wire logic [7:0] rxPacketByte,        // Received packet byte
    input wire logic rxGoodCheckSequence,       // Pulse: frame ended with good check
    input wire logic txTerminalInputClock,      // Link clock from terminal
    input wire logic txOwnOverheadBit,          // Internally generated overhead bit
    input wire logic txOverheadBitIn,           // Overhead value from terminal
    input wire logic txOverheadInsertStrobe,    // Terminal asks to insert
    input wire logic txSlotNoticeIn,            // Pin level, packet byte bit 7
    output logic rxTerminalOutputClock,         // Output clock to terminal
    output logic rxPayloadSerialOut,            // Serial payload
    output logic [3:0] rxPayloadNibbleOut,      // Nibble payload or packet lanes
    output logic rxFrameStartPulse,             // Frame start indicator
    output logic rxOverheadBoundaryPulse,       // Overhead boundary or packet bit 4
    output logic txNibbleBoundaryPulse,         // Last nibble or good check flag
    output logic txOverheadStrobeClock,         // Overhead clock
    output logic txSlotNoticeOut,               // Slot notice drive level
    output logic txSlotNoticeOe,                // High while notice pin is driven
    output logic txOverheadBit,                 // Overhead bit to the framer
    output logic txOverheadValid,               // txOverheadBit is fresh
    output logic txPacketBit7                   // Captured packet byte bit 7
);

    // =========================================================================
    // Receive domain state
    // =========================================================================
    typedef struct packed {
        logic divPhase;
        logic [1:0] bitCnt;
        logic [2:0] shift;
        logic firstSeen;
        logic fcsToggle;
        logic outClk;
        logic serOut;
        logic [3:0] nibOut;
        logic framePulse;
        logic ohPulse;
    } dfo_rx_s;

    // Transmit domain state
    typedef struct packed {
        logic [dfo_pkg::CNT_W-1:0] bitCnt;
        logic fcsSeen;
        logic notice;
        logic noticeOe;
        logic ohClk;
        logic nibPulse;
        logic ohBit;
        logic ohValid;
        logic hdlcBit7;
    } dfo_tx_s;

    dfo_rx_s rx_q;
    dfo_rx_s rx_d;
    dfo_tx_s tx_q;
    dfo_tx_s tx_d;
    logic [dfo_pkg::SYNC_W-1:0] toTx;
    logic [dfo_pkg::SYNC_W-1:0] inTx;
    logic txCe;
    logic txHdlc;
    logic txFcsEvent;
    logic rxTick;
    logic [1:0] rxPos;
    logic [dfo_pkg::CNT_W-1:0] txNext;

    // =========================================================================
    // Receive side: bit timing from ref_clk, two cycles per bit
    // =========================================================================
    assign rxTick = rx_q.divPhase;
    assign rxPos = rxLineFirst ? 2'h0 : rx_q.bitCnt; // Frame start realigns nibbles

    // Receive next state; clock enable low holds every field
    always_comb begin
        rx_d = rx_q;
        if (clkEn) begin
            rx_d.divPhase = ~rx_q.divPhase;
            rx_d.outClk = 1'b0;
            rx_d.fcsToggle = rx_q.fcsToggle ^ rxGoodCheckSequence; // Event becomes a toggle
            // Boundary pin: packet lane in packet mode, else pulse
            rx_d.ohPulse = hdlcOn ? rxPacketByte[dfo_pkg::RX_OHB_LANE]
                                  : rxOverheadFirst;
            if (rxTick) begin
                rx_d.bitCnt = rxPos + 2'h1;
                rx_d.shift = {rx_q.shift[1:0], rxLineBit};
                rx_d.firstSeen = rx_q.firstSeen | rxLineFirst;
                if (hdlcOn) begin
                    // Packet lanes move with each output clock rise
                    rx_d.outClk = 1'b1;
                    rx_d.nibOut = rxPacketByte[3:0];
                    rx_d.serOut = 1'b0;
                    rx_d.framePulse = 1'b0;
                end else if (!nibbleMode) begin
                    rx_d.outClk = 1'b1;
                    rx_d.serOut = rxLineBit;
                    rx_d.framePulse = rxLineFirst;
                    rx_d.nibOut = 4'h0;
                end else if (rxPos == dfo_pkg::NIB_LAST) begin
                    // Whole nibble ready: data and clock rise together
                    rx_d.outClk = 1'b1;
                    rx_d.nibOut = {rx_q.shift, rxLineBit};
                    rx_d.serOut = 1'b0;
                    rx_d.framePulse = rx_q.firstSeen;
                    rx_d.firstSeen = 1'b0;
                end
            end
        end
    end

    // Receive register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_q <= '0;
        end else begin
            rx_q <= rx_d;
        end
    end

    // =========================================================================
    // Crossing into the transmit domain
    // =========================================================================
    // Enable, packet mode and check toggle are all levels by the time they cross
    assign toTx[dfo_pkg::SY_CE] = clkEn;
    assign toTx[dfo_pkg::SY_HDLC] = hdlcOn;
    assign toTx[dfo_pkg::SY_FCS] = rx_q.fcsToggle;

    dfo_sync u_txSync (
        .clk(txTerminalInputClock),
        .reset(reset),
        .levelIn(toTx),
        .levelOut(inTx)
    );

    assign txCe = inTx[dfo_pkg::SY_CE];
    assign txHdlc = inTx[dfo_pkg::SY_HDLC];
    assign txFcsEvent = inTx[dfo_pkg::SY_FCS] ^ tx_q.fcsSeen;

    // =========================================================================
    // Transmit side: bit position, overhead handshake, boundary pulse
    // =========================================================================
    assign txNext = (tx_q.bitCnt == dfo_pkg::FRAME_LAST) ? '0
                                                          : tx_q.bitCnt + 10'h001;

    // Transmit next state; this channel's clock and modes only
    always_comb begin
        tx_d = tx_q;
        if (txCe) begin
            tx_d.bitCnt = txNext;
            tx_d.fcsSeen = inTx[dfo_pkg::SY_FCS];
            // Notice and clock rise in the bit period before each overhead bit
            // Clock runs in every mode; notice is a register so the pin needs no gate
            tx_d.ohClk = (txNext[5:0] & dfo_pkg::OH_MASK) == dfo_pkg::OH_PRE;
            tx_d.notice = tx_d.ohClk & ~txHdlc;
            tx_d.noticeOe = ~txHdlc;
            tx_d.ohValid = 1'b0;
            // Terminal answered the notice on the falling edge; latch it now
            if (tx_q.ohClk) begin
                tx_d.ohValid = 1'b1;
                if (txOverheadInsertStrobe && !txHdlc
                        && txNext != dfo_pkg::NONINS_POS) begin
                    tx_d.ohBit = txOverheadBitIn;
                end else begin
                    tx_d.ohBit = txOwnOverheadBit;
                end
            end
            // Shared pin: good check flag in packet mode, else last nibble
            tx_d.nibPulse = txHdlc ? txFcsEvent
                                   : (txNext == dfo_pkg::LAST_NIBBLE);
            if (txHdlc) begin
                tx_d.hdlcBit7 = txSlotNoticeIn;
            end
        end
    end

    // Transmit register
    always_ff @(posedge txTerminalInputClock or posedge reset) begin
        if (reset) begin
            tx_q <= '0;
        end else begin
            tx_q <= tx_d;
        end
    end

    // =========================================================================
    // Outputs, all from registers
    // =========================================================================
    assign rxTerminalOutputClock = rx_q.outClk;
    assign rxPayloadSerialOut = rx_q.serOut;
    assign rxPayloadNibbleOut = rx_q.nibOut;
    assign rxFrameStartPulse = rx_q.framePulse;
    assign rxOverheadBoundaryPulse = rx_q.ohPulse;
    assign txNibbleBoundaryPulse = tx_q.nibPulse;
    assign txOverheadStrobeClock = tx_q.ohClk;
    assign txSlotNoticeOut = tx_q.notice;
    assign txSlotNoticeOe = tx_q.noticeOe;
    assign txOverheadBit = tx_q.ohBit;
    assign txOverheadValid = tx_q.ohValid;
    assign txPacketBit7 = tx_q.hdlcBit7;

    // =========================================================================
    // Checks on the receive side
    // =========================================================================
    property p_rxSerialStart;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && rxTick && !hdlcOn && !nibbleMode && rxLineFirst)
            |=> rxFrameStartPulse ##1 (rxFrameStartPulse || !$past(clkEn));
    endproperty
    a_rxSerialStart: assert property (p_rxSerialStart)
        else $error("serial frame start not shown with first bit");

    sequence s_nibEdge;
        $rose(rxTerminalOutputClock);
    endsequence

    property p_rxNibbleStartEdges;
        @(posedge ref_clk) disable iff (reset)
        (nibbleMode && !hdlcOn && ($rose(rxFrameStartPulse) || $fell(rxFrameStartPulse)))
            |-> s_nibEdge;
    endproperty
    a_rxNibbleStartEdges: assert property (p_rxNibbleStartEdges)
        else $error("nibble frame start not aligned to a nibble period");

    property p_rxNibChange;
        @(posedge ref_clk) disable iff (reset)
        $changed(rxPayloadNibbleOut) |-> s_nibEdge;
    endproperty
    a_rxNibChange: assert property (p_rxNibChange)
        else $error("nibble outputs changed without output clock rise");

    property p_rxNibIdle;
        @(posedge ref_clk) disable iff (reset)
        (!nibbleMode && !hdlcOn && clkEn && rxTick) |=> rxPayloadNibbleOut == 4'h0;
    endproperty
    a_rxNibIdle: assert property (p_rxNibIdle)
        else $error("nibble payload driven outside nibble mode");

    property p_rxPacketLane;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && hdlcOn) |=> rxOverheadBoundaryPulse == $past(rxPacketByte[4]);
    endproperty
    a_rxPacketLane: assert property (p_rxPacketLane)
        else $error("packet bit 4 missing on boundary pin");

    property p_rxOhBoundary;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && !hdlcOn && rxOverheadFirst) |=> rxOverheadBoundaryPulse;
    endproperty
    a_rxOhBoundary: assert property (p_rxOhBoundary)
        else $error("overhead boundary pulse missing");

    // =========================================================================
    // Checks on the transmit side
    // =========================================================================
    sequence s_slot;
        $rose(txOverheadStrobeClock) && tx_q.notice;
    endsequence

    property p_txNotice;
        @(posedge txTerminalInputClock) disable iff (reset)
        s_slot |=> !tx_q.notice && txOverheadValid;
    endproperty
    a_txNotice: assert property (p_txNotice)
        else $error("slot notice not one cycle before overhead");

    property p_txInsert;
        @(posedge txTerminalInputClock) disable iff (reset)
        (txCe && tx_q.ohClk && !txHdlc && txOverheadInsertStrobe
            && txNext != dfo_pkg::NONINS_POS)
            |=> txOverheadBit == $past(txOverheadBitIn);
    endproperty
    a_txInsert: assert property (p_txInsert)
        else $error("terminal overhead bit not latched");

    property p_txKeepOwn;
        @(posedge txTerminalInputClock) disable iff (reset)
        (txCe && tx_q.ohClk && !txOverheadInsertStrobe)
            |=> txOverheadBit == $past(txOwnOverheadBit);
    endproperty
    a_txKeepOwn: assert property (p_txKeepOwn)
        else $error("internal overhead value not kept");

    property p_txBoundary;
        @(posedge txTerminalInputClock) disable iff (reset)
        (txCe && !txHdlc && txNext == dfo_pkg::LAST_NIBBLE) |=> txNibbleBoundaryPulse;
    endproperty
    a_txBoundary: assert property (p_txBoundary)
        else $error("last nibble boundary pulse missing");

endmodule : dfo_port

// file: tb/dfo_terminal.sv
// Terminal equipment model at the transmit overhead port of one channel.
// Assumes it is clocked by the same link clock that it hands to the port.
`timescale 1ns/1ps

module dfo_terminal (
    input wire logic txClk,       // Terminal input clock
    input wire logic noticePin,   // Resolved slot notice pin level
    input wire logic packetMode,  // Packet controller in use
    output logic insertStrobe,    // Insert request
    output logic overheadBit,     // Overhead value offered
    output logic pinDrive,        // Byte bit 7 level for the notice pin
    output logic pinOe            // High while the terminal drives the pin
);
    // =========================================
    // Overhead insertion
    // =========================================
    logic [1:0] slotCnt;
    logic offerVal;

    initial begin
        insertStrobe = 1'b0;
        overheadBit = 1'b0;
        pinDrive = 1'b0;
        pinOe = 1'b0;
        slotCnt = 2'h0;
        offerVal = 1'b1;
    end

    // Two slots in three are taken so the protected slot is hit as well
    always begin
        @(negedge txClk);
        if (noticePin === 1'b1 && !packetMode) begin
            slotCnt = (slotCnt == 2'h2) ? 2'h0 : slotCnt + 2'h1;
            if (slotCnt != 2'h2) begin
                insertStrobe = 1'b1;
                overheadBit = offerVal;
                offerVal = ~offerVal;
            end
            @(posedge txClk);
            #1;
            insertStrobe = 1'b0;
            overheadBit = ~overheadBit;  // Released line must not keep the value
        end
    end

    // Packet byte bit 7 changes every cycle so a stale capture shows
    always @(posedge txClk) begin
        #1;
        pinOe = packetMode;
        pinDrive = ~pinDrive;
    end
endmodule : dfo_terminal

// file: tb/tb_top.sv
// Self-checking bench for the frame-boundary and overhead port.
// Assumes the terminal model on the transmit side and a free link clock.
`timescale 1ns/1ps

module tb_top;
    // =========================================
    // Clocks, stimulus and instances
    // =========================================
    logic ref_clk = 1'b0;
    logic txClk = 1'b0;
    logic reset = 1'b1;
    logic clkEn = 1'b1;
    logic nibbleMode = 1'b0;
    logic hdlcOn = 1'b0;
    logic rxLineBit = 1'b0;
    logic rxLineFirst = 1'b0;
    logic rxOverheadFirst = 1'b0;
    logic [7:0] rxPacketByte = 8'h00;
    logic rxGoodCheck = 1'b0;
    logic ownBit = 1'b0;
    logic termIns, termBit, termDrive, termOe, noticePin;
    logic rxOutClk, serOut, frameStart, ohBoundary, nibBoundary, ohClk;
    logic noticeOut, noticeOe, ohBit, ohValid, pktBit7;
    logic [3:0] nibOut;
    int error_cnt = 0;
    int tests_run = 0;

    always #50 ref_clk = ~ref_clk;
    // A 15 ns link clock never puts a rising edge on a ref_clk edge
    always #7.5 txClk = ~txClk;
    // Device owns the pin unless handed over; an idle pin shows no stale level
    assign noticePin = noticeOe ? noticeOut : (termOe ? termDrive : ~noticeOut);

    dfo_port dfo_port_i (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn),
        .nibbleMode(nibbleMode), .hdlcOn(hdlcOn), .rxLineBit(rxLineBit),
        .rxLineFirst(rxLineFirst), .rxOverheadFirst(rxOverheadFirst),
        .rxPacketByte(rxPacketByte), .rxGoodCheckSequence(rxGoodCheck),
        .txTerminalInputClock(txClk), .txOwnOverheadBit(ownBit),
        .txOverheadBitIn(termBit), .txOverheadInsertStrobe(termIns),
        .txSlotNoticeIn(noticePin), .rxTerminalOutputClock(rxOutClk),
        .rxPayloadSerialOut(serOut), .rxPayloadNibbleOut(nibOut),
        .rxFrameStartPulse(frameStart), .rxOverheadBoundaryPulse(ohBoundary),
        .txNibbleBoundaryPulse(nibBoundary), .txOverheadStrobeClock(ohClk),
        .txSlotNoticeOut(noticeOut), .txSlotNoticeOe(noticeOe),
        .txOverheadBit(ohBit), .txOverheadValid(ohValid), .txPacketBit7(pktBit7));

    dfo_terminal dfo_terminal_i (.txClk(txClk), .noticePin(noticePin),
        .packetMode(hdlcOn), .insertStrobe(termIns), .overheadBit(termBit),
        .pinDrive(termDrive), .pinOe(termOe));

    // =========================================
    // Shared tasks
    // =========================================
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // One bit period: held across two edges, so the tick edge always sees it
    task automatic rx_step(input logic b, input logic f, input logic nib, input logic pkt,
        input logic [7:0] pb);
        @(posedge ref_clk);
        #1;
        rxLineBit = b;
        rxLineFirst = f;
        nibbleMode = nib;
        hdlcOn = pkt;
        rxPacketByte = pb;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : rx_step

    // =========================================
    // Receive scenarios
    // =========================================
    task automatic test_serial();
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            if (rxOutClk === 1'b1) break;
        end
        for (int i = 0; i < 6; i++) begin
            rx_step(i[0] ^ i[1], i == 0, 1'b0, 1'b0, 8'h00);
            check("outClk", rxOutClk, 1'b1);
            check("serOut", serOut, i[0] ^ i[1]);
            check("frameStart", frameStart, i == 0);
            check("nibIdle", nibOut, 4'h0);
        end
    endtask : test_serial

    task automatic test_nibble();
        logic [7:0] pat;
        pat = 8'hB6;
        for (int i = 0; i < 8; i++) begin
            rx_step(pat[7 - i], i == 0, 1'b1, 1'b0, 8'h00);
            if (i == 3) check("nibFirst", nibOut, 4'hB);
            if (i == 6) check("frameHold", frameStart, 1'b1);
            if (i == 6) check("nibHold", nibOut, 4'hB);
        end
        check("nibSecond", nibOut, 4'h6);
        check("frameEnd", frameStart, 1'b0);
        check("serIdle", serOut, 1'b0);
    endtask : test_nibble

    task automatic test_packet_rx();
        logic [7:0] pb;
        for (int i = 0; i < 2; i++) begin
            pb = (i == 0) ? 8'h14 : 8'h0B;
            rx_step(1'b0, 1'b0, 1'b0, 1'b1, pb);
            rx_step(1'b0, 1'b0, 1'b0, 1'b1, pb);
            check("lane2", nibOut[2], pb[2]);
            check("lanes", nibOut, pb[3:0]);
            check("lane4", ohBoundary, pb[4]);
        end
    endtask : test_packet_rx

    task automatic test_oh_boundary();
        rx_step(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        @(posedge ref_clk);
        #1;
        rxOverheadFirst = 1'b1;
        @(posedge ref_clk);
        #1;
        rxOverheadFirst = 1'b0;
        @(negedge ref_clk);
        check("ohFirst", ohBoundary, 1'b1);
        @(negedge ref_clk);
        check("ohAfter", ohBoundary, 1'b0);
    endtask : test_oh_boundary

    // =========================================
    // Transmit scenarios
    // =========================================
    // Reads right after the edge see the values of the cycle just ended
    task automatic test_overhead();
        int sinceNotice;
        int sinceBnd;
        logic pend, expBit, sawBnd, lastNotice, flip;
        sinceNotice = 0;
        sinceBnd = 0;
        pend = 1'b0;
        expBit = 1'b0;
        sawBnd = 1'b0;
        lastNotice = 1'b0;
        for (int i = 0; i < 2200; i++) begin
            @(posedge txClk);
            sinceNotice++;
            sinceBnd++;
            flip = pend;
            if (sawBnd) check("ohValid", ohValid, pend);
            if (sawBnd && pend) check("ohBit", ohBit, expBit);
            pend = 1'b0;
            if (nibBoundary === 1'b1) begin
                if (sawBnd) check("frameLen", sinceBnd, 1024);
                sawBnd = 1'b1;
                sinceBnd = 0;
            end
            if (sawBnd && noticeOut === 1'b1) begin
                check("ohClk", ohClk, 1'b1);
                check("noticeDrv", noticeOe, 1'b1);
                check("noticeOnce", lastNotice, 1'b0);
                check("spacing", sinceNotice, 64);
                pend = 1'b1;
                expBit = (termIns === 1'b1 && sinceBnd != 3) ? termBit : ownBit;
            end
            if (noticeOut === 1'b1) sinceNotice = 0;
            lastNotice = noticeOut;
            // Own value moves only after a slot, so its sampling edge is unambiguous
            if (flip) begin
                #1;
                ownBit = ~ownBit;
            end
        end
    endtask : test_overhead

    task automatic test_packet_tx();
        int pulses;
        logic lastPin;
        pulses = 0;
        lastPin = 1'b0;
        @(posedge ref_clk);
        #1;
        hdlcOn = 1'b1;
        repeat (6) @(posedge txClk);
        fork
            begin
                @(posedge ref_clk);
                #1;
                rxGoodCheck = 1'b1;
                @(posedge ref_clk);
                #1;
                rxGoodCheck = 1'b0;
            end
        join_none
        for (int i = 0; i < 1100; i++) begin
            @(posedge txClk);
            if (nibBoundary === 1'b1) pulses++;
            if (i > 0) check("bit7", pktBit7, lastPin);
            check("noticeOe", noticeOe, 1'b0);
            check("noticeQuiet", noticeOut, 1'b0);
            lastPin = noticePin;
        end
        check("goodCheck", pulses, 1);
    endtask : test_packet_tx

    // Enable low must hold every receive output, even with new input
    task automatic test_freeze();
        rx_step(1'b0, 1'b0, 1'b0, 1'b1, 8'h1A);
        @(posedge ref_clk);
        #1;
        clkEn = 1'b0;
        rxPacketByte = 8'h05;
        repeat (4) @(negedge ref_clk);
        check("frozenLanes", nibOut, 4'hA);
        check("frozenBit4", ohBoundary, 1'b1);
        @(posedge ref_clk);
        #1;
        clkEn = 1'b1;
    endtask : test_freeze

    // =========================================
    // Sequence and watchdog
    // =========================================
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        test_serial();
        test_nibble();
        test_packet_rx();
        test_oh_boundary();
        test_overhead();
        test_packet_tx();
        test_freeze();
        conclude();
    end

    // Whole run needs about 56 us; over three times that means a hang
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
endmodule : tb_top
